/* rtl/sms_subframe_mask_sequencer.v */
// Sub-frame mask sequencer of the timing generator: configuration
// registers, timing-generator clock enable, and the per-sub-frame gates
// for overload window, illumination, calculation and power-down.
// Assumes a single ref_clk domain; the register port is driven by the
// device's serial-interface register logic on the same clock.
`timescale 1ns/1ps
`include "sms_defines.vh"

module sms_subframe_mask_sequencer #(
   parameter ADDR_W   = `SMS_ADDR_W,
   parameter DATA_W   = `SMS_DATA_W,
   parameter POS_W    = `SMS_POS_W,
   parameter CLKCNT_W = `SMS_CLKCNT_W
) (
   input  wire                ref_clk,
   input  wire                rstn,
   input  wire                run,
   input  wire [CLKCNT_W-1:0] subframeClockCount,
   input  wire                regWrEn,
   input  wire                regRdEn,
   input  wire [ADDR_W-1:0]   regAddr,
   input  wire [DATA_W-1:0]   regWrData,
   output reg  [DATA_W-1:0]   regRdData_q,
   output reg                 regRdValid_q,
   output reg                 regHit_q,
   output reg                 tgClkEn_q,
   output wire [POS_W-1:0]    subframeIndex,
   output reg                 subframeStart_q,
   output reg                 frameStart_q,
   output reg                 averagingActive_q,
   output reg                 ovlWindowAllow_q,
   output reg                 illumAllow_q,
   output reg                 calcAllow_q,
   output reg                 powerDownAllow_q
);

   localparam NMASK = `SMS_NUM_MASKS;
   // The phase accumulator counts nanoseconds: one step per reference
   // clock, one enable each time a timing-generator period is crossed.
   localparam [`SMS_PHASE_W-1:0] PHASE_STEP = `SMS_REF_CLK_NS;
   localparam [`SMS_PHASE_W-1:0] PHASE_WRAP = `SMS_TG_CLK_NS;

   // Mask registers, indexed by the SMS_MASK_* constants.
   reg  [DATA_W-1:0]        maskReg_q [0:NMASK-1];
   reg  [DATA_W-1:0]        countsReg_q;
   reg  [`SMS_PHASE_W-1:0]  phase_q;
   reg  [`SMS_PHASE_W-1:0]  phase_d;
   reg                      tgClkEn_d;
   reg  [NMASK-1:0]         inRange;
   reg  [NMASK-1:0]         maskHit;
   reg  [DATA_W-1:0]        rdMux;
   reg                      rdHit;
   reg                      runSeen_q;
   reg                      subframeStart_d;
   reg                      frameStart_d;
   reg                      averagingActive_d;
   reg  [NMASK-1:0]         gates_d;
   wire                     boundary;
   wire [POS_W-1:0]         frameLength;
   wire [POS_W-1:0]         avgField;
   wire [POS_W-1:0]         nextIndex;
   wire                     subframeEnd;
   wire                     frameEnd;
   wire                     wrOvl;
   wire                     wrIllum;
   wire                     wrCalc;
   wire                     wrPdn;
   wire                     wrCounts;

   assign wrOvl    = regWrEn & (regAddr == `SMS_OFS_OVL_MASK);
   assign wrIllum  = regWrEn & (regAddr == `SMS_OFS_ILLUM_MASK);
   assign wrCalc   = regWrEn & (regAddr == `SMS_OFS_CALC_MASK);
   assign wrPdn    = regWrEn & (regAddr == `SMS_OFS_PDN_MASK);
   assign wrCounts = regWrEn & (regAddr == `SMS_OFS_COUNTS);

   always @(posedge ref_clk) begin
      if (!rstn) begin
         maskReg_q[`SMS_MASK_OVL] <= `SMS_RST_OVL_MASK;
      end else if (wrOvl) begin
         maskReg_q[`SMS_MASK_OVL] <= regWrData;
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         maskReg_q[`SMS_MASK_ILLUM] <= `SMS_RST_ILLUM_MASK;
      end else if (wrIllum) begin
         maskReg_q[`SMS_MASK_ILLUM] <= regWrData;
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         maskReg_q[`SMS_MASK_CALC] <= `SMS_RST_CALC_MASK;
      end else if (wrCalc) begin
         maskReg_q[`SMS_MASK_CALC] <= regWrData;
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         maskReg_q[`SMS_MASK_PDN] <= `SMS_RST_PDN_MASK;
      end else if (wrPdn) begin
         maskReg_q[`SMS_MASK_PDN] <= regWrData;
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         countsReg_q <= `SMS_RST_COUNTS;
      end else if (wrCounts) begin
         countsReg_q <= regWrData;
      end
   end

   assign frameLength = countsReg_q[`SMS_FIRST_MSB:`SMS_FIRST_LSB];
   assign avgField    = countsReg_q[`SMS_LAST_MSB:`SMS_LAST_LSB];

   // Registered read port; every field is read/write, so a read returns
   // exactly what was last written.  Unmapped offsets read as zero.
   always @* begin
      rdMux = {DATA_W{1'b0}};
      rdHit = 1'b1;
      case (regAddr)
         `SMS_OFS_OVL_MASK: begin
            rdMux = maskReg_q[`SMS_MASK_OVL];
         end
         `SMS_OFS_ILLUM_MASK: begin
            rdMux = maskReg_q[`SMS_MASK_ILLUM];
         end
         `SMS_OFS_CALC_MASK: begin
            rdMux = maskReg_q[`SMS_MASK_CALC];
         end
         `SMS_OFS_PDN_MASK: begin
            rdMux = maskReg_q[`SMS_MASK_PDN];
         end
         `SMS_OFS_COUNTS: begin
            rdMux = countsReg_q;
         end
         default: begin
            rdHit = 1'b0;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         regRdData_q  <= {DATA_W{1'b0}};
         regRdValid_q <= 1'b0;
         regHit_q     <= 1'b0;
      end else begin
         regRdValid_q <= regRdEn;
         if (regRdEn) begin
            regRdData_q <= rdMux;
         end
         if (regRdEn || regWrEn) begin
            regHit_q <= rdHit;
         end
      end
   end

   // 25 ns clock from 10 ns
   // The timing-generator clock is 2.5 reference cycles, so a phase
   // accumulator alternates gaps of 2 and 3 cycles.  The average rate is
   // exact; single sub-frames jitter by at most one reference cycle.
   always @* begin
      phase_d   = phase_q + PHASE_STEP;
      tgClkEn_d = 1'b0;
      if (phase_d >= PHASE_WRAP) begin
         phase_d   = phase_d - PHASE_WRAP;
         tgClkEn_d = 1'b1;
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn || !run) begin
         phase_q   <= {`SMS_PHASE_W{1'b0}};
         tgClkEn_q <= 1'b0;
      end else begin
         phase_q   <= phase_d;
         tgClkEn_q <= tgClkEn_d;
      end
   end

   sms_frame_counter #(
      .POS_W    (POS_W),
      .CLKCNT_W (CLKCNT_W)
   ) uFrameCounter (
      .ref_clk            (ref_clk),
      .rstn               (rstn),
      .run                (run),
      .tgClkEn            (tgClkEn_q),
      .subframeClockCount (subframeClockCount),
      .frameLength        (frameLength),
      .subframeIndex_q    (subframeIndex),
      .subframeEnd        (subframeEnd),
      .frameEnd           (frameEnd)
   );

   // The gates are evaluated for the sub-frame about to begin, so they
   // change together with subframeStart_q and hold for the whole sub-frame.
   assign nextIndex = frameEnd ? {POS_W{1'b0}} :
                      (subframeEnd ? subframeIndex +
                                     {{(POS_W-1){1'b0}}, 1'b1} :
                                     subframeIndex);

   genvar gi;
   generate
      for (gi = 0; gi < NMASK; gi = gi + 1) begin : gMask
         always @* begin
            inRange[gi] =
               (nextIndex >= maskReg_q[gi][`SMS_FIRST_MSB:`SMS_FIRST_LSB]) &&
               (nextIndex <= maskReg_q[gi][`SMS_LAST_MSB:`SMS_LAST_LSB]);
         end
      end
   endgenerate

   always @* begin
      maskHit                 = inRange;
      maskHit[`SMS_MASK_PDN]  = ~inRange[`SMS_MASK_PDN];
   end

   // A boundary is the end of a sub-frame or the first cycle of a run;
   // the first sub-frame after run rises is a frame start as well.
   assign boundary = subframeEnd | ~runSeen_q;

   // Gates reload only at a boundary, so a register write in the middle
   // of a sub-frame waits for the next one instead of cutting a gate.
   // Nothing here checks that the frame length covers the averaged
   // count; software has to keep that order.
   always @* begin
      subframeStart_d   = boundary;
      frameStart_d      = frameEnd | ~runSeen_q;
      averagingActive_d = averagingActive_q;
      gates_d           = {powerDownAllow_q, calcAllow_q, illumAllow_q,
                           ovlWindowAllow_q};
      if (boundary) begin
         averagingActive_d = (nextIndex <= avgField);
         gates_d           = maskHit;
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn) begin
         runSeen_q         <= 1'b0;
         subframeStart_q   <= 1'b0;
         frameStart_q      <= 1'b0;
         averagingActive_q <= 1'b0;
         ovlWindowAllow_q  <= 1'b0;
         illumAllow_q      <= 1'b0;
         calcAllow_q       <= 1'b0;
         powerDownAllow_q  <= 1'b0;
      end else if (!run) begin
         runSeen_q         <= 1'b0;
         subframeStart_q   <= 1'b0;
         frameStart_q      <= 1'b0;
         averagingActive_q <= 1'b0;
         ovlWindowAllow_q  <= 1'b0;
         illumAllow_q      <= 1'b0;
         calcAllow_q       <= 1'b0;
         powerDownAllow_q  <= 1'b0;
      end else begin
         runSeen_q         <= 1'b1;
         subframeStart_q   <= subframeStart_d;
         frameStart_q      <= frameStart_d;
         averagingActive_q <= averagingActive_d;
         ovlWindowAllow_q  <= gates_d[`SMS_MASK_OVL];
         illumAllow_q      <= gates_d[`SMS_MASK_ILLUM];
         calcAllow_q       <= gates_d[`SMS_MASK_CALC];
         powerDownAllow_q  <= gates_d[`SMS_MASK_PDN];
      end
   end

endmodule // sms_subframe_mask_sequencer

/* rtl/sms_defines.vh */
// Constants for the sub-frame mask sequencer: register offsets, field
// positions, reset values and timing figures.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SMS_DEFINES_VH
`define SMS_DEFINES_VH

`define SMS_ADDR_W          8
`define SMS_DATA_W          24
`define SMS_POS_W           12
`define SMS_CLKCNT_W        16

`define SMS_OFS_OVL_MASK    8'h99
`define SMS_OFS_ILLUM_MASK  8'h9C
`define SMS_OFS_CALC_MASK   8'h9D
`define SMS_OFS_PDN_MASK    8'h9E
`define SMS_OFS_COUNTS      8'h9F

`define SMS_LAST_MSB        23
`define SMS_LAST_LSB        12
`define SMS_FIRST_MSB       11
`define SMS_FIRST_LSB       0

`define SMS_RST_OVL_MASK    24'h000001
`define SMS_RST_ILLUM_MASK  24'hFFF000
`define SMS_RST_CALC_MASK   24'h000000
`define SMS_RST_PDN_MASK    24'h000000
`define SMS_RST_COUNTS      24'h000000

`define SMS_NUM_MASKS       4
`define SMS_MASK_OVL        0
`define SMS_MASK_ILLUM      1
`define SMS_MASK_CALC       2
`define SMS_MASK_PDN        3

`define SMS_TG_CLK_NS       25
`define SMS_REF_CLK_NS      10
`define SMS_PHASE_W         6

`endif

/* rtl/sms_frame_counter.v */
// Sub-frame timer and sub-frame index counter for one frame.
// Assumes tgClkEn is a one-cycle pulse on ref_clk at the timing-generator
// rate and that all inputs come from logic on ref_clk.
`timescale 1ns/1ps
`include "sms_defines.vh"

module sms_frame_counter #(
   parameter POS_W    = `SMS_POS_W,
   parameter CLKCNT_W = `SMS_CLKCNT_W
) (
   input  wire                ref_clk,
   input  wire                rstn,
   input  wire                run,
   input  wire                tgClkEn,
   input  wire [CLKCNT_W-1:0] subframeClockCount,
   input  wire [POS_W-1:0]    frameLength,
   output reg  [POS_W-1:0]    subframeIndex_q,
   output wire                subframeEnd,
   output wire                frameEnd
);

   reg  [CLKCNT_W-1:0] tgCount_q;
   wire [CLKCNT_W-1:0] tgLast;

   // A zero count would never end a sub-frame; treat it as one clock.
   assign tgLast = (subframeClockCount == {CLKCNT_W{1'b0}}) ?
                   {CLKCNT_W{1'b0}} :
                   subframeClockCount - {{(CLKCNT_W-1){1'b0}}, 1'b1};

   assign subframeEnd = run & tgClkEn & (tgCount_q >= tgLast);
   assign frameEnd = subframeEnd & (subframeIndex_q >= frameLength);

   always @(posedge ref_clk) begin
      if (!rstn || !run) begin
         tgCount_q <= {CLKCNT_W{1'b0}};
      end else if (subframeEnd) begin
         tgCount_q <= {CLKCNT_W{1'b0}};
      end else if (tgClkEn) begin
         tgCount_q <= tgCount_q + {{(CLKCNT_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge ref_clk) begin
      if (!rstn || !run) begin
         subframeIndex_q <= {POS_W{1'b0}};
      end else if (frameEnd) begin
         subframeIndex_q <= {POS_W{1'b0}};
      end else if (subframeEnd) begin
         subframeIndex_q <= subframeIndex_q + {{(POS_W-1){1'b0}}, 1'b1};
      end
   end

endmodule // sms_frame_counter

/* dv/sms_subframe_mask_sequencer_checker.sv */
// Port-level checker for the sub-frame mask sequencer.
// Assumes one ref_clk domain and a synchronous active-low rstn.
`timescale 1ns/1ps
module sms_checker (
   input wire        ref_clk,
   input wire        rstn,
   input wire        run,
   input wire        regRdEn,
   input wire        regWrEn,
   input wire [7:0]  regAddr,
   input wire [23:0] regRdData_q,
   input wire        regRdValid_q,
   input wire        regHit_q,
   input wire        tgClkEn_q,
   input wire [11:0] subframeIndex,
   input wire        subframeStart_q,
   input wire        frameStart_q,
   input wire        averagingActive_q,
   input wire        ovlWindowAllow_q,
   input wire        illumAllow_q,
   input wire        calcAllow_q,
   input wire        powerDownAllow_q
);
   wire [3:0] gates = {ovlWindowAllow_q, illumAllow_q, calcAllow_q,
                       powerDownAllow_q};
   wire unmapped = !(regAddr inside {8'h99, 8'h9C, 8'h9D, 8'h9E, 8'h9F});
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   AST_RD_ANSWER: assert property (regRdEn |=> regRdValid_q)
      else $error("read not answered");
   AST_RD_PULSE: assert property (regRdValid_q |-> $past(regRdEn))
      else $error("read valid without read");
   AST_UNMAPPED: assert property (regRdEn && unmapped |=>
      !regHit_q && regRdData_q == 24'h000000)
      else $error("unmapped read not refused");
   AST_TG_GAP: assert property (tgClkEn_q |=> !tgClkEn_q)
      else $error("tg enable too fast");
   // At 25 ns on a 10 ns clock no gap may exceed two idle cycles.
   AST_TG_RATE: assert property (run[*6] |-> tgClkEn_q ||
      $past(tgClkEn_q) || $past(tgClkEn_q, 2))
      else $error("tg enable too slow");
   AST_FRAME_IDX: assert property (frameStart_q |->
      subframeStart_q && subframeIndex == 12'h000)
      else $error("frame start not at index zero");
   AST_AVG_FIRST: assert property (frameStart_q |-> averagingActive_q)
      else $error("first sub-frame not averaged");
   AST_GATES_HOLD: assert property (run && $past(run) &&
      !subframeStart_q |-> $stable(gates))
      else $error("gate changed inside a sub-frame");
   AST_IDLE: assert property (!run ##1 !run |-> !subframeStart_q &&
      gates == 4'h0 && subframeIndex == 12'h000)
      else $error("sequencer active while stopped");
   cover property (frameStart_q);
   cover property (regRdEn && unmapped);
   cover property (subframeStart_q && powerDownAllow_q && !calcAllow_q);
endmodule // sms_checker

bind sms_subframe_mask_sequencer sms_checker u_chk (
   .ref_clk           (ref_clk),
   .rstn              (rstn),
   .run               (run),
   .regRdEn           (regRdEn),
   .regWrEn           (regWrEn),
   .regAddr           (regAddr),
   .regRdData_q       (regRdData_q),
   .regRdValid_q      (regRdValid_q),
   .regHit_q          (regHit_q),
   .tgClkEn_q         (tgClkEn_q),
   .subframeIndex     (subframeIndex),
   .subframeStart_q   (subframeStart_q),
   .frameStart_q      (frameStart_q),
   .averagingActive_q (averagingActive_q),
   .ovlWindowAllow_q  (ovlWindowAllow_q),
   .illumAllow_q      (illumAllow_q),
   .calcAllow_q       (calcAllow_q),
   .powerDownAllow_q  (powerDownAllow_q)
);

/* dv/sms_subframe_mask_sequencer_tb.sv */
// Self-checking bench for the sub-frame mask sequencer.
// Assumes the design top and its checker are compiled alongside.
`timescale 1ns/1ps
module sms_subframe_mask_sequencer_tb;
   reg ref_clk = 0, rstn = 0, run = 0, regWrEn = 0, regRdEn = 0;
   reg [15:0] subframeClockCount = 16'h0002;
   reg [7:0]  regAddr = 8'h00;
   reg [23:0] regWrData = 24'h000000;
   wire [23:0] regRdData_q;
   wire [11:0] subframeIndex;
   wire regRdValid_q, regHit_q, tgClkEn_q, subframeStart_q, frameStart_q;
   wire averagingActive_q, ovlWindowAllow_q, illumAllow_q, calcAllow_q;
   wire powerDownAllow_q;
   reg [7:0]  ofs [0:4] = '{8'h99, 8'h9C, 8'h9D, 8'h9E, 8'h9F};
   reg [23:0] rstv [0:4] = '{24'h000001, 24'hFFF000, 24'h000000,
                             24'h000000, 24'h000000};
   reg [23:0] m [0:4];
   reg [23:0] d;
   integer mismatches = 0, samplesChecked = 0, cyc = 0;
   integer i, k, c, idx, len, avg, n, nn, first;

   sms_subframe_mask_sequencer u_dut (
      .ref_clk            (ref_clk),
      .rstn               (rstn),
      .run                (run),
      .subframeClockCount (subframeClockCount),
      .regWrEn            (regWrEn),
      .regRdEn            (regRdEn),
      .regAddr            (regAddr),
      .regWrData          (regWrData),
      .regRdData_q        (regRdData_q),
      .regRdValid_q       (regRdValid_q),
      .regHit_q           (regHit_q),
      .tgClkEn_q          (tgClkEn_q),
      .subframeIndex      (subframeIndex),
      .subframeStart_q    (subframeStart_q),
      .frameStart_q       (frameStart_q),
      .averagingActive_q  (averagingActive_q),
      .ovlWindowAllow_q   (ovlWindowAllow_q),
      .illumAllow_q       (illumAllow_q),
      .calcAllow_q        (calcAllow_q),
      .powerDownAllow_q   (powerDownAllow_q)
   );

   always #5 ref_clk = ~ref_clk;

   task give_verdict;
      $display("checks %0d mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end

   task chk(input [23:0] got, input [23:0] exp);
      samplesChecked = samplesChecked + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task wr(input [7:0] a, input [23:0] v);
      @(posedge ref_clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge ref_clk);
      regWrEn <= 1'b0;
   endtask

   task rd(input [7:0] a, output [23:0] v);
      @(posedge ref_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      #1;
      chk(regRdValid_q, 24'h000001);
      v = regRdData_q;
   endtask

   function logic inr(input [11:0] x, input [23:0] w);
      inr = x >= w[11:0] && x <= w[23:12];
   endfunction

   initial begin
      void'($urandom(38));
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      for (i = 0; i < 5; i++) begin
         rd(ofs[i], d);
         chk(d, rstv[i]);
      end
      wr(8'h9B, 24'hFFFFFF);
      #1;
      chk(regHit_q, 24'h000000);
      rd(8'h9F, d);
      chk(d, 24'h000000);
      rd(8'h9A, d);
      chk(d, 24'h000000);
      chk(regHit_q, 24'h000000);
      for (k = 0; k < 6; k++) begin
         len = $urandom_range(2, 5);
         avg = $urandom_range(0, len);
         for (i = 0; i < 4; i++)
            m[i] = {12'($urandom_range(0, len)), 12'($urandom_range(0, len))};
         m[4] = {12'(avg), 12'(len)};
         if (k == 0) begin
            for (i = 0; i < 4; i++)
               m[i][23:12] = 12'(avg);
            m[0][11:0] = 12'($urandom_range(0, 1));
            m[2][11:0] = 12'(avg);
         end
         for (i = 0; i < 5; i++)
            wr(ofs[i], m[i]);
         for (i = 0; i < 5; i++) begin
            rd(ofs[i], d);
            chk(d, m[i]);
         end
         n = $urandom_range(0, 5);
         nn = (n == 0) ? 1 : n;
         @(posedge ref_clk);
         subframeClockCount <= 16'(n);
         run <= 1'b1;
         idx = 0;
         first = 1;
         repeat (2 * (len + 1)) begin
            c = 0;
            do begin
               @(posedge ref_clk);
               #1;
               c = c + 1;
            end while (!subframeStart_q && c < 60);
            if (!first)
               chk(c * 2 >= nn * 5 - 2 && c * 2 <= nn * 5 + 2, 1);
            first = 0;
            chk(frameStart_q, idx == 0);
            chk(subframeIndex, idx);
            chk(averagingActive_q, idx <= avg);
            chk({ovlWindowAllow_q, illumAllow_q, calcAllow_q, powerDownAllow_q},
                {inr(idx, m[0]), inr(idx, m[1]), inr(idx, m[2]),
                 !inr(idx, m[3])});
            idx = (idx == len) ? 0 : idx + 1;
         end
         @(posedge ref_clk);
         run <= 1'b0;
         repeat (2) @(posedge ref_clk);
      end
      // Reset in mid-run restarts the frame and restores every register.
      run <= 1'b1;
      repeat (30) @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk({subframeStart_q, frameStart_q}, 24'h000003);
      chk(subframeIndex, 24'h000000);
      chk(averagingActive_q, 24'h000001);
      chk({ovlWindowAllow_q, illumAllow_q, calcAllow_q, powerDownAllow_q},
          {inr(0, rstv[0]), inr(0, rstv[1]), inr(0, rstv[2]),
           !inr(0, rstv[3])});
      for (i = 0; i < 5; i++) begin
         rd(ofs[i], d);
         chk(d, rstv[i]);
      end
      give_verdict;
   end
endmodule // sms_subframe_mask_sequencer_tb
